// ### core/aic_top.sv
`timescale 1ns/1ps

// How it works
// - Transmitted SDA stays steady while SCL high
// - SDA changes only while SCL is low
// - SDA falling with SCL high is start
// - SDA rising with SCL high is stop
// - Every byte holds exactly eight bits
// - Ninth clock after each byte acknowledges
// - Bytes move most significant bit first
// - Byte sender releases SDA during acknowledge
// - Byte receiver holds SDA low through acknowledge
// - Slave acks address; master acks read data
// - Clip select picks low or high threshold
// - Low-power pin high enables bus, low standby
// - Turn-on diagnostics only in power-stage standby
// - Permanent diagnostics when protection trips while active
// - Offset flagged only while playing with enable
// - Address bit zero chooses write or read
// - Read returns two diagnostic bytes in turn
module aic_top
   import aic_pkg::*;
(
   // System clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Link oversampling clock
   input  wire logic       clk_link,
   // Two-wire bus, open drain data
   input  wire logic       scl,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   // Straps and mode pins
   input  wire logic       addrPinA,
   input  wire logic       addrPinB,
   input  wire logic       lowPowerPin,
   // Analog comparator levels
   input  wire logic       clipLowThr,
   input  wire logic       clipHighThr,
   input  wire logic       thermWarn,
   input  wire logic       protTrip,
   input  wire logic [4:0] faultCh1,
   input  wire logic [4:0] faultCh2,
   // Amplifier controls
   output logic            clippingIndicatorOutput,
   output logic            clipThresholdSelectBit,
   output logic            unmute,
   output logic            gainLow,
   output logic            powerRun,
   output logic            highEffMode,
   output logic            lineDriverDiag,
   output logic            diagEnable,
   output logic            offsetDetEnable,
   output logic            deviceStandby
);

   ////////////////////////////////////////////////////////////////////////
   // Link domain state
   typedef struct packed {
      aic_link_e  state;
      logic       sclP;
      logic       sdaP;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic [1:0] byteIdx;
      logic       rdMode;
      logic       acked;
      logic       sdaOe;
      logic       sdaOut;
      logic [7:0] wrData;
      logic       wrIdx;
      logic       wrTgl;
      logic       rdReqTgl;
   } aic_link_s;
   aic_link_s l;
   aic_link_s next_l;
   // System domain state
   typedef struct packed {
      logic        wrSeen;
      logic        rdSeen;
      logic [7:0]  ib1;
      logic [7:0]  ib2;
      logic [15:0] snap;
      logic        clipInd;
      logic        standby;
   } aic_sys_s;
   aic_sys_s s;
   aic_sys_s next_s;

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for both domains
   logic [4:0]  linkSync;
   logic [16:0] sysSync;
   logic        sclS, sdaS, addrAS, addrBS, busEnS;
   logic        lowPowerS, clipLowS, clipHighS, thermS, protS;
   logic        wrTglS, rdReqS;
   logic [4:0]  fault1S, fault2S;

   aic_sync #(.W(5)) uLinkSync (
      .clk  (clk_link),
      .rst  (rst),
      .din  ({lowPowerPin, addrPinB, addrPinA, sdaIn, scl}),
      .dout (linkSync)
   );
   assign {busEnS, addrBS, addrAS, sdaS, sclS} = linkSync;

   // Pins and link toggles arrive in the system domain
   aic_sync #(.W(17)) uSysSync (
      .clk  (clk_sys),
      .rst  (rst),
      .din  ({l.rdReqTgl, l.wrTgl, faultCh2, faultCh1, protTrip,
              thermWarn, clipHighThr, clipLowThr, lowPowerPin}),
      .dout (sysSync)
   );
   assign {rdReqS, wrTglS, fault2S, fault1S, protS, thermS, clipHighS,
           clipLowS, lowPowerS} = sysSync;

   ////////////////////////////////////////////////////////////////////////
   // Link engine: bus is sampled, not clocked, so glitches on SCL stay
   // harmless at the cost of needing a link clock well above SCL
   logic startC, stopC, sclRise, sclFall, addrHit;

   always_comb
   begin
      next_l      = l;
      next_l.sclP = sclS;
      next_l.sdaP = sdaS;
      startC  = l.sclP & sclS & l.sdaP & ~sdaS;
      stopC   = l.sclP & sclS & ~l.sdaP & sdaS;
      sclRise = ~l.sclP & sclS;
      sclFall = l.sclP & ~sclS;
      addrHit = (l.shift[7:1] == {AIC_ADDR_HI, addrBS, addrAS});
      if (!busEnS)
      begin
         // Bus ignored and released while in standby
         next_l.state  = AIC_IDLE;
         next_l.sdaOe  = 1'b0;
         next_l.bitCnt = 4'h0;
      end
      else if (startC)
      begin
         next_l.state   = AIC_ADDR;
         next_l.sdaOe   = 1'b0;
         next_l.bitCnt  = 4'h0;
         next_l.byteIdx = 2'h0;
      end
      else if (stopC)
      begin
         next_l.state = AIC_IDLE;
         next_l.sdaOe = 1'b0;
      end
      else
      begin
         case (l.state)
            AIC_ADDR:
            begin
               if (sclRise)
               begin
                  next_l.shift  = {l.shift[6:0], sdaS};
                  next_l.bitCnt = l.bitCnt + 4'h1;
               end
               else if (sclFall && l.bitCnt == AIC_BYTE_BITS)
               begin
                  if (addrHit)
                  begin
                     next_l.sdaOe  = 1'b1;
                     next_l.rdMode = l.shift[0];
                     next_l.state  = AIC_ADDR_ACK;
                     // Snapshot request well ahead of first read bit
                     if (l.shift[0])
                        next_l.rdReqTgl = ~l.rdReqTgl;
                  end
                  else
                     next_l.state = AIC_HOLD;
               end
            end
            AIC_ADDR_ACK:
            begin
               if (sclFall)
               begin
                  next_l.bitCnt = 4'h0;
                  // A write shifts all eight bits over this load
                  next_l.state  = l.rdMode ? AIC_RD_BYTE : AIC_WR_BYTE;
                  next_l.shift  = s.snap[15:8];
                  next_l.sdaOe  = l.rdMode & ~s.snap[15];
               end
            end
            AIC_WR_BYTE:
            begin
               if (sclRise)
               begin
                  next_l.shift  = {l.shift[6:0], sdaS};
                  next_l.bitCnt = l.bitCnt + 4'h1;
               end
               else if (sclFall && l.bitCnt == AIC_BYTE_BITS)
               begin
                  next_l.sdaOe = 1'b1;
                  next_l.state = AIC_WR_ACK;
                  // Extra bytes are acknowledged but not kept
                  if (l.byteIdx < AIC_WR_BYTES)
                  begin
                     next_l.wrData = l.shift;
                     next_l.wrIdx  = l.byteIdx[0];
                     next_l.wrTgl  = ~l.wrTgl;
                  end
               end
            end
            AIC_WR_ACK:
            begin
               if (sclFall)
               begin
                  next_l.sdaOe  = 1'b0;
                  next_l.bitCnt = 4'h0;
                  next_l.state  = AIC_WR_BYTE;
                  if (l.byteIdx < AIC_WR_BYTES)
                     next_l.byteIdx = l.byteIdx + 2'h1;
               end
            end
            AIC_RD_BYTE:
            begin
               if (sclRise)
                  next_l.bitCnt = l.bitCnt + 4'h1;
               else if (sclFall && l.bitCnt == AIC_BYTE_BITS)
               begin
                  next_l.sdaOe = 1'b0;
                  next_l.state = AIC_RD_ACK;
               end
               else if (sclFall)
               begin
                  // Data moves only after SCL has gone low
                  next_l.shift = {l.shift[6:0], 1'b0};
                  next_l.sdaOe = ~l.shift[6];
               end
            end
            AIC_RD_ACK:
            begin
               if (sclRise)
                  next_l.acked = ~sdaS;
               else if (sclFall)
               begin
                  next_l.bitCnt = 4'h0;
                  if (l.acked && l.byteIdx == 2'h0)
                  begin
                     next_l.byteIdx = 2'h1;
                     next_l.shift   = s.snap[7:0];
                     next_l.sdaOe   = ~s.snap[7];
                     next_l.state   = AIC_RD_BYTE;
                  end
                  else
                     next_l.state = AIC_HOLD;
               end
            end
            AIC_HOLD, AIC_IDLE:
               next_l.sdaOe = 1'b0;
            default:
            begin
               next_l.state = AIC_IDLE;
               next_l.sdaOe = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge clk_link or posedge rst)
   begin
      if (rst)
      begin
         l       <= '0;
         l.state <= AIC_IDLE;
         l.sclP  <= 1'b1;
         l.sdaP  <= 1'b1;
      end
      else
         l <= next_l;
   end

   ////////////////////////////////////////////////////////////////////////
   // Diagnostic windows and channels
   logic       powerOff, playing, rdEv, done1;
   logic [4:0] flags1, flags2;

   // Power stage off either by pin or by the run bit
   assign powerOff = s.standby | ~s.ib2[AIC_IB2_RUN];
   assign playing  = ~powerOff & s.ib1[AIC_IB1_UNMUTE];
   assign rdEv     = rdReqS ^ s.rdSeen;
   aic_diag_chan uDiag1 (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .turnOnWin (s.ib1[AIC_IB1_DIAG] & powerOff & ~s.standby),
      .permWin   (s.ib1[AIC_IB1_DIAG] & ~powerOff & protS),
      .offsetWin (s.ib1[AIC_IB1_OFFSET] & playing),
      .clear     (rdEv),
      .fault     (fault1S),
      .flags     (flags1),
      .done      (done1)
   );
   aic_diag_chan uDiag2 (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .turnOnWin (s.ib1[AIC_IB1_DIAG] & powerOff & ~s.standby),
      .permWin   (s.ib1[AIC_IB1_DIAG] & ~powerOff & protS),
      .offsetWin (s.ib1[AIC_IB1_OFFSET] & playing),
      .clear     (rdEv),
      .fault     (fault2S),
      .flags     (flags2),
      .done      ()
   );

   ////////////////////////////////////////////////////////////////////////
   // System side: instruction bytes, snapshot, clip indicator
   always_comb
   begin
      logic wrEv;
      wrEv          = wrTglS ^ s.wrSeen;
      next_s        = s;
      next_s.wrSeen = wrTglS;
      next_s.rdSeen = rdReqS;
      next_s.standby = ~lowPowerS;
      // Link holds data steady for a whole byte after each toggle
      if (wrEv && l.wrIdx)
         next_s.ib2 = l.wrData;
      else if (wrEv)
         next_s.ib1 = l.wrData;
      if (!lowPowerS)
      begin
         next_s.ib1 = AIC_IB1_RESET;
         next_s.ib2 = AIC_IB2_RESET;
      end
      if (rdEv)
      begin
         next_s.snap[15:8] = {thermS, done1, 1'b0, flags1};
         next_s.snap[7:0]  = {s.ib1[AIC_IB1_OFFSET], 2'h0, flags2};
      end
      // Threshold picked by the select bit
      next_s.clipInd = s.ib1[AIC_IB1_CLIP] ? clipHighS : clipLowS;
   end
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s         <= '0;
         s.ib1     <= AIC_IB1_RESET;
         s.ib2     <= AIC_IB2_RESET;
         s.standby <= 1'b1;
      end
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops
   assign sdaOut                  = l.sdaOut;
   assign sdaOe                   = l.sdaOe;
   assign clippingIndicatorOutput = s.clipInd;
   assign clipThresholdSelectBit  = s.ib1[AIC_IB1_CLIP];
   assign unmute                  = s.ib1[AIC_IB1_UNMUTE];
   assign gainLow                 = s.ib1[AIC_IB1_GAIN];
   assign diagEnable              = s.ib1[AIC_IB1_DIAG];
   assign offsetDetEnable         = s.ib1[AIC_IB1_OFFSET];
   assign powerRun                = s.ib2[AIC_IB2_RUN];
   assign highEffMode             = s.ib2[AIC_IB2_HIEFF];
   assign lineDriverDiag          = s.ib2[AIC_IB2_LINE];
   assign deviceStandby           = s.standby;
endmodule : aic_top

// ### core/aic_pkg.sv
package aic_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus framing
   localparam logic [3:0] AIC_BYTE_BITS   = 4'h8;   // Data bits per byte
   localparam logic [1:0] AIC_WR_BYTES    = 2'h2;   // Instruction bytes kept
   localparam logic [4:0] AIC_ADDR_HI     = 5'h1A;  // Fixed address bits 6..2

   ////////////////////////////////////////////////////////////////////////
   // First instruction byte fields
   localparam int         AIC_IB1_CLIP    = 0;      // Clip threshold select
   localparam int         AIC_IB1_UNMUTE  = 2;
   localparam int         AIC_IB1_GAIN    = 4;      // 1 selects the low gain
   localparam int         AIC_IB1_OFFSET  = 5;      // Offset detection enable
   localparam int         AIC_IB1_DIAG    = 6;      // Diagnostics enable

   // Second instruction byte fields
   localparam int         AIC_IB2_HIEFF   = 1;
   localparam int         AIC_IB2_LINE    = 3;      // Line driver diagnostics
   localparam int         AIC_IB2_RUN     = 4;      // 0 keeps power stage off

   // Values after reset and in standby
   localparam logic [7:0] AIC_IB1_RESET   = 8'h00;
   localparam logic [7:0] AIC_IB2_RESET   = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Diagnostic flag positions inside a diagnostic byte
   localparam int         AIC_DB_GND      = 0;
   localparam int         AIC_DB_VCC      = 1;
   localparam int         AIC_DB_OPEN     = 2;      // Open load or offset
   localparam int         AIC_DB_LOAD     = 3;
   localparam int         AIC_DB_PERM     = 4;      // 1 after permanent diag
   localparam int         AIC_DB_DONE     = 6;      // First byte only
   localparam int         AIC_DB_THERM    = 7;      // First byte only
   localparam int         AIC_DB_OFFACT   = 7;      // Second byte only

   ////////////////////////////////////////////////////////////////////////
   // Link engine states
   typedef enum logic [7:0] {
      AIC_IDLE     = 8'h01,
      AIC_ADDR     = 8'h02,
      AIC_ADDR_ACK = 8'h04,
      AIC_WR_BYTE  = 8'h08,
      AIC_WR_ACK   = 8'h10,
      AIC_RD_BYTE  = 8'h20,
      AIC_RD_ACK   = 8'h40,
      AIC_HOLD     = 8'h80
   } aic_link_e;

endpackage : aic_pkg

// ### core/aic_sync.sv
`timescale 1ns/1ps

module aic_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels in and out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } aic_sync_s;

   aic_sync_s r;
   aic_sync_s next_r;

   // First stage feeds only the second
   always_comb
   begin
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= next_r;
   end

   assign dout = r.s2;

endmodule : aic_sync

// ### core/aic_diag_chan.sv
`timescale 1ns/1ps

module aic_diag_chan
   import aic_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Evaluation windows
   input  wire logic       turnOnWin,
   input  wire logic       permWin,
   input  wire logic       offsetWin,
   input  wire logic       clear,
   // Comparator levels: offset, short load, open, Vcc, ground
   input  wire logic [4:0] fault,
   // Sticky flags in diagnostic byte order
   output logic      [4:0] flags,
   output logic            done
);

   typedef struct packed {
      logic [4:0] flags;
      logic       done;
   } aic_diag_s;

   aic_diag_s r;
   aic_diag_s next_r;

   // Flags stay until read; a set in the read cycle survives the clear
   always_comb
   begin
      logic [4:0] setMask;
      setMask = 5'h00;
      if (turnOnWin)
      begin
         setMask[AIC_DB_GND]  = fault[0];
         setMask[AIC_DB_VCC]  = fault[1];
         setMask[AIC_DB_OPEN] = fault[2];
         setMask[AIC_DB_LOAD] = fault[3];
      end
      if (permWin)
      begin
         setMask[AIC_DB_GND]  = fault[0];
         setMask[AIC_DB_VCC]  = fault[1];
         setMask[AIC_DB_LOAD] = fault[3];
         setMask[AIC_DB_PERM] = 1'b1;
      end
      if (offsetWin && fault[4])
         setMask[AIC_DB_OPEN] = 1'b1;
      next_r.flags = (clear ? 5'h00 : r.flags) | setMask;
      next_r.done  = (clear ? 1'b0 : r.done) | turnOnWin | permWin;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= next_r;
   end

   assign flags = r.flags;
   assign done  = r.done;

endmodule : aic_diag_chan

// ### verif/aic_top_sva.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////
module aic_top_sva (
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   // Bus pins
   input wire logic scl,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // Mode pin and comparators
   input wire logic lowPowerPin,
   input wire logic clipLowThr,
   input wire logic clipHighThr,
   // Amplifier controls
   input wire logic clippingIndicatorOutput,
   input wire logic clipThresholdSelectBit,
   input wire logic unmute,
   input wire logic gainLow,
   input wire logic powerRun,
   input wire logic highEffMode,
   input wire logic lineDriverDiag,
   input wire logic diagEnable,
   input wire logic offsetDetEnable,
   input wire logic deviceStandby
);
   logic [2:0] sysAge;
   logic       selNow;
   logic       ibAny;

   // Comparator picked by the select bit, and any control set
   assign selNow = clipThresholdSelectBit ? clipHighThr : clipLowThr;
   assign ibAny = clipThresholdSelectBit | unmute | gainLow | powerRun
                | highEffMode | lineDriverDiag | diagEnable | offsetDetEnable;

   // Age since reset; pipelines hold reset values at first
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sysAge <= 3'h0;
      else if (sysAge != 3'h7)
         sysAge <= sysAge + 3'h1;
   end

   ////////////////////////////////////////////////////////////////
   property p_oeStandby;
      @(posedge clk_link) disable iff (rst)
      !lowPowerPin [*6] |-> !sdaOe;
   endproperty
   a_oeStandby: assert property (p_oeStandby)
      else $error("sda pulled while in standby");
   property p_sdaOutZero;
      @(posedge clk_sys) disable iff (rst) !sdaOut;
   endproperty
   a_sdaOutZero: assert property (p_sdaOutZero)
      else $error("sda output drives high");
   property p_oeEdge;
      @(posedge clk_link) disable iff (rst) $changed(sdaOe) |-> !scl;
   endproperty
   a_oeEdge: assert property (p_oeEdge)
      else $error("sda changed while scl high");
   property p_ackHold;
      @(posedge clk_link) disable iff (rst)
      $rose(scl) && sdaOe |-> sdaOe [*4];
   endproperty
   a_ackHold: assert property (p_ackHold)
      else $error("sda low not held through clock pulse");
   property p_stopRelease;
      @(posedge clk_link) disable iff (rst)
      scl && $past(scl) && $rose(sdaIn) |-> !sdaOe [*3];
   endproperty
   a_stopRelease: assert property (p_stopRelease)
      else $error("sda pulled after stop");
   property p_clipSel;
      @(posedge clk_sys) disable iff (rst)
      sysAge == 3'h7 && selNow == $past(selNow) && selNow ==
      $past(selNow, 2) && selNow == $past(selNow, 3)
      |-> clippingIndicatorOutput == selNow;
   endproperty
   a_clipSel: assert property (p_clipSel)
      else $error("clip output not from selected threshold");
   property p_standbyFollow;
      @(posedge clk_sys) disable iff (rst)
      sysAge == 3'h7 && lowPowerPin == $past(lowPowerPin) && lowPowerPin
      == $past(lowPowerPin, 2) && lowPowerPin == $past(lowPowerPin, 3)
      |-> deviceStandby == !lowPowerPin;
   endproperty
   a_standbyFollow: assert property (p_standbyFollow)
      else $error("standby does not follow low-power pin");
   property p_standbyIbZero;
      @(posedge clk_sys) disable iff (rst) deviceStandby [*8] |-> !ibAny;
   endproperty
   a_standbyIbZero: assert property (p_standbyIbZero)
      else $error("controls set during standby");

   // Main scenarios reached
   c_ack: cover property (@(posedge clk_link) $rose(scl) && sdaOe);
   c_clipHigh: cover property (@(posedge clk_sys) clipThresholdSelectBit);
   c_standby: cover property (@(posedge clk_sys) deviceStandby [*8]);
endmodule : aic_top_sva

bind aic_top aic_top_sva u_sva (.clk_sys, .rst, .clk_link, .scl, .sdaIn,
   .sdaOut, .sdaOe, .lowPowerPin, .clipLowThr, .clipHighThr,
   .clippingIndicatorOutput, .clipThresholdSelectBit, .unmute, .gainLow,
   .powerRun, .highEffMode, .lineDriverDiag, .diagEnable, .offsetDetEnable,
   .deviceStandby);

// ### verif/aic_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////
// Bus master; SDA is only ever pulled low, the pull-up does the rest
module aic_host_model (
   // Link clock paces every bus step
   input  wire logic clk_link,
   // Resolved data line
   input  wire logic sdaLine,
   // Driven wires
   output logic      scl,
   output logic      sdaPull
);
   // Bus idles released, clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_link);
   endtask : tick
   // One pulse; data set mid-low so the slave never sees it move
   task automatic bitOut(input logic b, output logic seen);
      tick(2);
      sdaPull <= ~b;
      tick(3);
      scl <= 1'b1;
      tick(5);
      seen = sdaLine;
      scl <= 1'b0;
   endtask : bitOut
   // Start pulls SDA with SCL high, stop lets it rise
   task automatic frame(input logic isStart);
      tick(2);
      sdaPull <= ~isStart;
      tick(3);
      scl <= 1'b1;
      tick(5);
      sdaPull <= isStart;
      tick(5);
      if (isStart)
         scl <= 1'b0;
   endtask : frame
   // Leading bits of a byte; fewer than eight only to abort
   task automatic bits(input logic [7:0] v, input int n);
      logic s;
      for (int i = 7; i > 7 - n; i--)
         bitOut(v[i], s);
   endtask : bits
   task automatic sendByte(input logic [7:0] v, output logic ack);
      logic s;
      bits(v, 8);
      bitOut(1'b1, s);
      ack = ~s;
   endtask : sendByte
   task automatic readByte(input logic ackIt, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitOut(1'b1, s);
         v[i] = s;
      end
      bitOut(~ackIt, s);
   endtask : readByte
endmodule : aic_host_model

// ### verif/aic_top_tb.sv
`timescale 1ns/1ps

module aic_top_tb;
   import aic_pkg::*;

   logic       clk_sys, rst, clk_link, scl, sdaPull, sdaLine, sdaOut, sdaOe;
   logic       addrPinA, addrPinB, lowPowerPin, clipLowThr, clipHighThr;
   logic       thermWarn, protTrip, clippingIndicatorOutput, unmute;
   logic       clipThresholdSelectBit, gainLow, powerRun, highEffMode;
   logic       lineDriverDiag, diagEnable, offsetDetEnable, deviceStandby;
   logic [4:0] faultCh1, faultCh2;
   logic [7:0] ownAddr;
   int         numErrors, totalChecks;

   // Pull-up: line low while either side pulls
   assign sdaLine = ~(sdaOe | sdaPull);
   assign ownAddr = {AIC_ADDR_HI, 1'b0, 1'b1, 1'b0};

   aic_top dut (.clk_sys, .rst, .clk_link, .scl, .sdaIn(sdaLine), .sdaOut,
      .sdaOe, .addrPinA, .addrPinB, .lowPowerPin, .clipLowThr, .clipHighThr,
      .thermWarn, .protTrip, .faultCh1, .faultCh2, .clippingIndicatorOutput,
      .clipThresholdSelectBit, .unmute, .gainLow, .powerRun, .highEffMode,
      .lineDriverDiag, .diagEnable, .offsetDetEnable, .deviceStandby);
   aic_host_model host (.clk_link, .sdaLine, .scl, .sdaPull);

   // Clocks; link phase offset so edges never line up
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      clk_link = 1'b0;
      #3.7;
      forever #40 clk_link = ~clk_link;
   end

   ////////////////////////////////////////////////////////////////
   task automatic tallyAndFinish();
      if (numErrors == 0 && totalChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tallyAndFinish
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
         numErrors++;
      end
   endtask : check
   task automatic waitSys(int n);
      repeat (n) @(posedge clk_sys);
   endtask : waitSys
   function automatic logic [7:0] ctrl();
      return {clipThresholdSelectBit, unmute, gainLow, offsetDetEnable,
              diagEnable, powerRun, highEffMode, lineDriverDiag};
   endfunction : ctrl
   function automatic logic [7:0] expCtrl(logic [7:0] b1, logic [7:0] b2);
      return {b1[0], b1[2], b1[4], b1[5], b1[6], b2[4], b2[1], b2[3]};
   endfunction : expCtrl
   task automatic wr(logic [7:0] a, b1, b2, output logic [2:0] acks);
      host.frame(1'b1);
      host.sendByte(a, acks[2]);
      host.sendByte(b1, acks[1]);
      host.sendByte(b2, acks[0]);
      host.frame(1'b0);
      waitSys(20);
   endtask : wr
   // Master acks the first byte and refuses the second
   task automatic rd(output logic [7:0] d1, d2, output logic ak);
      host.frame(1'b1);
      host.sendByte(ownAddr | 8'h01, ak);
      host.readByte(1'b1, d1);
      host.readByte(1'b0, d2);
      host.frame(1'b0);
      waitSys(20);
   endtask : rd

   ////////////////////////////////////////////////////////////////
   // Two writes with asymmetric bytes; a reversed order shows up
   task automatic tWrite();
      logic [7:0] b1, b2;
      logic [2:0] acks;
      for (int i = 0; i < 2; i++)
      begin
         b1 = i ? 8'h10 : 8'h75;
         b2 = i ? 8'h02 : 8'h1A;
         wr(ownAddr, b1, b2, acks);
         check("acks", {5'h00, acks}, 8'h07);
         check("ctrl", ctrl(), expCtrl(b1, b2));
         check("clip", {7'h00, clippingIndicatorOutput},
               {7'h00, ~b1[0]});
      end
   endtask : tWrite
   task automatic tBadAddr();
      logic [2:0] acks;
      wr(ownAddr ^ 8'h02, 8'h00, 8'h00, acks);
      check("badAcks", {5'h00, acks}, 8'h00);
      check("badCtrl", ctrl(), expCtrl(8'h10, 8'h02));
   endtask : tBadAddr
   // Restart after half an address byte
   task automatic tAbort();
      logic [2:0] acks;
      host.frame(1'b1);
      host.bits(ownAddr, 4);
      wr(ownAddr, 8'h75, 8'h1A, acks);
      check("abAcks", {5'h00, acks}, 8'h07);
      check("abCtrl", ctrl(), expCtrl(8'h75, 8'h1A));
   endtask : tAbort
   task automatic tStandby();
      logic [2:0] acks;
      @(posedge clk_sys);
      lowPowerPin <= 1'b0;
      waitSys(40);
      check("stby", {7'h00, deviceStandby}, 8'h01);
      check("stbyCtrl", ctrl(), 8'h00);
      wr(ownAddr, 8'h75, 8'h1A, acks);
      check("stbyAcks", {5'h00, acks}, 8'h00);
      lowPowerPin <= 1'b1;
      waitSys(40);
      check("wake", {7'h00, deviceStandby}, 8'h00);
   endtask : tStandby
   // Turn-on, permanent and offset windows; first read clears stale flags
   task automatic tDiag();
      logic [7:0] ib1, ib2, m, e1, e2, d1, d2;
      logic [2:0] acks;
      logic       ak;
      for (int i = 0; i < 3; i++)
      begin
         case (i)
            0: {ib1, ib2, m, e1, e2} = {8'h40, 8'h00, 8'hBF, 8'h85, 8'h02};
            1: {ib1, ib2, m, e1, e2} = {8'h40, 8'h10, 8'hBF, 8'h18, 8'h00};
            default: {ib1, ib2, m, e1, e2} =
               {8'h64, 8'h10, 8'hAF, 8'h04, 8'h84};
         endcase
         @(posedge clk_sys);
         thermWarn <= (i == 0);
         protTrip <= (i == 1);
         faultCh1 <= i == 0 ? 5'h05 : i == 1 ? 5'h08 : 5'h10;
         faultCh2 <= i == 0 ? 5'h02 : i == 1 ? 5'h00 : 5'h10;
         wr(ownAddr, ib1, ib2, acks);
         rd(d1, d2, ak);
         rd(d1, d2, ak);
         check("dAck", {7'h00, ak}, 8'h01);
         check("db1", d1 & m, e1 & m);
         check("db2", d2 & 8'hEF, e2 & 8'hEF);
      end
   endtask : tDiag

   ////////////////////////////////////////////////////////////////
   // Guard against a hung bus
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      numErrors++;
      tallyAndFinish();
   end
   // Main sequence
   initial
   begin
      numErrors = 0;
      totalChecks = 0;
      rst = 1'b1;
      addrPinA = 1'b1;
      addrPinB = 1'b0;
      lowPowerPin = 1'b1;
      clipLowThr = 1'b1;
      clipHighThr = 1'b0;
      thermWarn = 1'b0;
      protTrip = 1'b0;
      faultCh1 = 5'h00;
      faultCh2 = 5'h00;
      waitSys(20);
      rst <= 1'b0;
      waitSys(60);
      tWrite();
      tBadAddr();
      tAbort();
      tStandby();
      tDiag();
      tallyAndFinish();
   end
endmodule : aic_top_tb
